// ---- design/ssts_map.vh ----
// ssts_map.vh: constants for the service self-test sequencer
// assumes inclusion by bare name from the design files
`ifndef SSTS_MAP_VH
`define SSTS_MAP_VH
`define SSTS_CLK_HZ        20000000
`define SSTS_STEP_MS       500
`define SSTS_STEP_CYC      ((`SSTS_CLK_HZ / 1000) * `SSTS_STEP_MS)
`define SSTS_FLASH_MS      250
`define SSTS_FLASH_CYC     ((`SSTS_CLK_HZ / 1000) * `SSTS_FLASH_MS)
`define SSTS_SEL_RAM       4'h0
`define SSTS_SEL_ROM       4'h1
`define SSTS_SEL_PRM       4'h2
`define SSTS_SEL_DISP      4'h3
`define SSTS_SEL_ADC0      4'h4
`define SSTS_SEL_ADC1      4'h5
`define SSTS_SEL_ADC2      4'h6
`define SSTS_SEL_ADC3      4'h7
`define SSTS_SEL_RELAY     4'h8
`define SSTS_SEL_ECHO      4'h9
`define SSTS_IND_IDLE      3'h0
`define SSTS_IND_BUSY      3'h1
`define SSTS_IND_PASS      3'h2
`define SSTS_IND_FAIL      3'h3
`define SSTS_IND_LIVE      3'h4
`define SSTS_IND_DISP      3'h5
`define SSTS_IND_RELAY     3'h6
`define SSTS_IND_ECHO      3'h7
`define SSTS_RLY_STEPS     4'h8
`endif

// ---- design/ssts_mem_scan.v ----
// ssts_mem_scan.v: one-pass memory scanner with error flag and 16-bit sum
// assumes the memory answers read data one cycle after the address
`timescale 1ns/1ps
module ssts_mem_scan #(
  parameter AW = 8
) (
  input  wire          ref_clk,
  input  wire          srst,
  input  wire          start,
  output reg  [AW-1:0] addr_r,
  output reg           rd_r,
  input  wire [7:0]    rd_data,
  input  wire          rd_err,
  output reg           done_r,
  output reg           err_r,
  output reg  [15:0]   sum_r
);
  reg          busy_r;
  reg          last_r;
  reg          vld_r;

  always @(posedge ref_clk) begin
    if (srst) begin
      addr_r <= {AW{1'b0}};
      rd_r   <= 1'b0;
      done_r <= 1'b0;
      err_r  <= 1'b0;
      sum_r  <= 16'h0000;
      busy_r <= 1'b0;
      last_r <= 1'b0;
      vld_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      vld_r  <= rd_r;
      if (start) begin
        addr_r <= {AW{1'b0}};
        rd_r   <= 1'b1;
        err_r  <= 1'b0;
        sum_r  <= 16'h0000;
        busy_r <= 1'b1;
        last_r <= 1'b0;
      end else if (busy_r) begin
        if (vld_r) begin
          sum_r <= sum_r + {8'h00, rd_data};
          if (rd_err)
            err_r <= 1'b1;
        end
        if (rd_r) begin
          if (&addr_r) begin
            rd_r   <= 1'b0;
            last_r <= 1'b1;
          end else begin
            addr_r <= addr_r + {{(AW-1){1'b0}}, 1'b1};
          end
        end else if (last_r && !vld_r) begin
          busy_r <= 1'b0;
          last_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- design/ssts_top.v ----
// ssts_top.v: service self-test sequencer, menu gate, test runs and indications
// assumes synchronous inputs on ref_clk, a byte receiver/transmitter outside
`timescale 1ns/1ps
`include "ssts_map.vh"

module ssts_top #(
  parameter AW        = 8,
  parameter STEP_CYC  = `SSTS_STEP_CYC,
  parameter FLASH_CYC = `SSTS_FLASH_CYC
) (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire        svc_key,
  input  wire        menu_exit,
  input  wire        test_start,
  input  wire [3:0]  test_sel,
  output reg         group_avail_r,
  output reg  [AW-1:0] mem_addr_r,
  output reg         mem_rd_r,
  output reg  [1:0]  mem_space_r,
  input  wire [7:0]  mem_rd_data,
  input  wire        mem_rd_err,
  output reg  [1:0]  adc_chan_r,
  output reg         adc_src_id_r,
  output reg         adc_req_r,
  input  wire        adc_valid,
  input  wire [15:0] adc_mvolt,
  output reg  [2:0]  ind_r,
  output reg  [15:0] disp_val_r,
  output reg         disp_all_on_r,
  output reg         err_lamp_r,
  output reg  [3:0]  relay_sw_r,
  output reg         relay_gauge_channel_one_r,
  output reg         relay_gauge_channel_two_r,
  output reg         relay_err_r,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  output reg         tx_valid_r,
  output reg  [7:0]  tx_data_r
);
  localparam ST_IDLE  = 6'b000001;
  localparam ST_MEM   = 6'b000010;
  localparam ST_HOLD  = 6'b000100;
  localparam ST_ADC   = 6'b001000;
  localparam ST_RELAY = 6'b010000;
  localparam ST_ECHO  = 6'b100000;

  reg  [5:0]  state_r;
  reg  [5:0]  state_nxt;
  reg         strap_done_r;
  reg  [3:0]  sel_r;
  reg         flash_en_r;
  reg  [31:0] flash_cnt_r;
  reg  [31:0] step_cnt_r;
  reg  [3:0]  rly_step_r;
  reg         scan_start_r;
  reg  [6:0]  rly_vec_nxt;

  wire [AW-1:0] scan_addr;
  wire          scan_rd;
  wire          scan_done;
  wire          scan_err;
  wire [15:0]   scan_sum;

  wire          sel_ok;
  wire          can_take;
  wire          go;
  wire          step_wrap;
  wire          rly_last;

  // memory and relay runs finish on their own; only leaving the group cuts them short
  // an unknown select code is refused so it cannot stop a failure's flashing
  assign sel_ok    = (test_sel <= `SSTS_SEL_ECHO);
  assign can_take  = (state_r == ST_IDLE) || (state_r == ST_HOLD) ||
                     (state_r == ST_ADC)  || (state_r == ST_ECHO);
  assign go        = test_start && group_avail_r && !menu_exit && sel_ok && can_take;
  assign step_wrap = (step_cnt_r == STEP_CYC - 1);
  assign rly_last  = step_wrap && (rly_step_r == `SSTS_RLY_STEPS - 4'h1);

  ssts_mem_scan #(.AW(AW)) u_scan (
    .ref_clk (ref_clk),
    .srst    (srst),
    .start   (scan_start_r),
    .addr_r  (scan_addr),
    .rd_r    (scan_rd),
    .rd_data (mem_rd_data),
    .rd_err  (mem_rd_err),
    .done_r  (scan_done),
    .err_r   (scan_err),
    .sum_r   (scan_sum)
  );

  // key is caught on the first clock after reset release, never under reset
  always @(posedge ref_clk) begin
    if (srst) begin
      strap_done_r  <= 1'b0;
      group_avail_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r  <= 1'b1;
      group_avail_r <= svc_key;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_HOLD, ST_ADC, ST_ECHO: begin
        if (menu_exit)
          state_nxt = ST_IDLE;
        else if (go) begin
          case (test_sel)
            `SSTS_SEL_RAM, `SSTS_SEL_ROM, `SSTS_SEL_PRM: state_nxt = ST_MEM;
            `SSTS_SEL_DISP:  state_nxt = ST_HOLD;
            `SSTS_SEL_ADC0, `SSTS_SEL_ADC1,
            `SSTS_SEL_ADC2, `SSTS_SEL_ADC3: state_nxt = ST_ADC;
            `SSTS_SEL_RELAY: state_nxt = ST_RELAY;
            `SSTS_SEL_ECHO:  state_nxt = ST_ECHO;
            default:         state_nxt = state_r;
          endcase
        end
      end
      ST_MEM: begin
        if (menu_exit)
          state_nxt = ST_IDLE;
        else if (scan_done)
          state_nxt = ST_HOLD;
      end
      ST_RELAY: begin
        if (menu_exit)
          state_nxt = ST_IDLE;
        else if (rly_last)
          state_nxt = ST_HOLD;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      state_r       <= ST_IDLE;
      sel_r         <= 4'h0;
      scan_start_r  <= 1'b0;
      ind_r         <= `SSTS_IND_IDLE;
      disp_val_r    <= 16'h0000;
      disp_all_on_r <= 1'b0;
      flash_en_r    <= 1'b0;
      mem_space_r   <= 2'h0;
      adc_chan_r    <= 2'h0;
      adc_src_id_r  <= 1'b0;
      adc_req_r     <= 1'b0;
      tx_valid_r    <= 1'b0;
      tx_data_r     <= 8'h00;
      step_cnt_r    <= 32'h00000000;
      rly_step_r    <= 4'h0;
    end else begin
      state_r      <= state_nxt;
      scan_start_r <= 1'b0;
      tx_valid_r   <= 1'b0;
      adc_req_r    <= 1'b0;
      if (state_nxt != ST_IDLE && state_r != state_nxt || go) begin
        disp_all_on_r <= 1'b0;
        flash_en_r    <= 1'b0;
      end
      if (menu_exit) begin
        ind_r         <= `SSTS_IND_IDLE;
        flash_en_r    <= 1'b0;
        disp_all_on_r <= 1'b0;
      end else if (go) begin
        sel_r      <= test_sel;
        step_cnt_r <= 32'h00000000;
        rly_step_r <= 4'h0;
        case (test_sel)
          `SSTS_SEL_RAM, `SSTS_SEL_ROM, `SSTS_SEL_PRM: begin
            mem_space_r  <= test_sel[1:0];
            scan_start_r <= 1'b1;
            ind_r        <= `SSTS_IND_BUSY;
          end
          `SSTS_SEL_DISP: begin
            ind_r         <= `SSTS_IND_DISP;
            disp_all_on_r <= 1'b1;
          end
          `SSTS_SEL_ADC0, `SSTS_SEL_ADC1, `SSTS_SEL_ADC2, `SSTS_SEL_ADC3: begin
            adc_chan_r   <= test_sel[1:0];
            adc_src_id_r <= test_sel[1];
            ind_r        <= `SSTS_IND_LIVE;
          end
          `SSTS_SEL_RELAY: ind_r <= `SSTS_IND_RELAY;
          `SSTS_SEL_ECHO:  ind_r <= `SSTS_IND_ECHO;
          default:         ind_r <= ind_r;
        endcase
      end else begin
        case (state_r)
          ST_MEM: begin
            if (scan_done) begin
              ind_r      <= scan_err ? `SSTS_IND_FAIL : `SSTS_IND_PASS;
              flash_en_r <= scan_err;
              // checksum shown after either outcome of the program memory test
              if (sel_r == `SSTS_SEL_ROM)
                disp_val_r <= scan_sum;
            end
          end
          ST_ADC: begin
            // request every cycle so the reading keeps following the input
            adc_req_r <= 1'b1;
            if (adc_valid)
              disp_val_r <= adc_mvolt;
          end
          ST_RELAY: begin
            if (step_wrap) begin
              step_cnt_r <= 32'h00000000;
              rly_step_r <= rly_step_r + 4'h1;
            end else begin
              step_cnt_r <= step_cnt_r + 32'h00000001;
            end
          end
          ST_ECHO: begin
            if (rx_valid) begin
              tx_valid_r <= 1'b1;
              tx_data_r  <= rx_data;
            end
          end
          default: ind_r <= ind_r;
        endcase
      end
    end
  end

  // memory port registered from the scanner in every state, not only while a memory test runs
  always @(posedge ref_clk) begin
    if (srst) begin
      mem_addr_r <= {AW{1'b0}};
      mem_rd_r   <= 1'b0;
    end else begin
      mem_addr_r <= scan_addr;
      mem_rd_r   <= scan_rd;
    end
  end

  // vector order: relays 4..1, gauge channel one, gauge channel two, error relay
  // step 0 and any step past the error relay keep all released
  always @* begin
    rly_vec_nxt = 7'h00;
    case (rly_step_r)
      4'h1:    rly_vec_nxt = 7'h08;
      4'h2:    rly_vec_nxt = 7'h10;
      4'h3:    rly_vec_nxt = 7'h20;
      4'h4:    rly_vec_nxt = 7'h40;
      4'h5:    rly_vec_nxt = 7'h04;
      4'h6:    rly_vec_nxt = 7'h02;
      4'h7:    rly_vec_nxt = 7'h01;
      default: rly_vec_nxt = 7'h00;
    endcase
  end

  // one relay energised in each of steps 1 to 7, none in step 0
  always @(posedge ref_clk) begin
    if (srst) begin
      relay_sw_r                <= 4'h0;
      relay_gauge_channel_one_r <= 1'b0;
      relay_gauge_channel_two_r <= 1'b0;
      relay_err_r               <= 1'b0;
    end else if (state_r == ST_RELAY) begin
      {relay_sw_r, relay_gauge_channel_one_r, relay_gauge_channel_two_r, relay_err_r} <= rly_vec_nxt;
    end else begin
      relay_sw_r                <= 4'h0;
      relay_gauge_channel_one_r <= 1'b0;
      relay_gauge_channel_two_r <= 1'b0;
      relay_err_r               <= 1'b0;
    end
  end

  // lamp blinks at a fixed rate while a memory failure is being shown
  always @(posedge ref_clk) begin
    if (srst) begin
      flash_cnt_r <= 32'h00000000;
      err_lamp_r  <= 1'b0;
    end else if (!flash_en_r) begin
      flash_cnt_r <= 32'h00000000;
      err_lamp_r  <= 1'b0;
    end else if (flash_cnt_r == FLASH_CYC - 1) begin
      flash_cnt_r <= 32'h00000000;
      err_lamp_r  <= ~err_lamp_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h00000001;
    end
  end
endmodule

// ---- test/ssts_host_model.sv ----
// ssts_host_model.sv: host side of the serial echo test
// assumes bytes cross as one-cycle valid strobes on ref_clk
`timescale 1ns/1ps
module ssts_host_model (
  input  wire logic       ref_clk,
  input  wire logic       send_en,
  input  wire logic [7:0] send_byte,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid_r,
  input  wire logic [7:0] tx_data_r,
  output logic [7:0]      last_echo,
  output logic [7:0]      echo_xor,
  output logic [7:0]      n_echo
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    last_echo = 8'h00;
    echo_xor = 8'h00;
    n_echo = 8'h00;
  end
  always @(posedge ref_clk) begin
    rx_valid <= send_en;
    // idle data flips each cycle so a stale byte is never taken for a fresh one
    rx_data <= send_en ? send_byte : ~rx_data;
    if (tx_valid_r) begin
      last_echo <= tx_data_r;
      echo_xor <= echo_xor ^ tx_data_r;
      n_echo <= n_echo + 8'h01;
    end
  end
endmodule

// ---- test/ssts_top_checker.sv ----
// ssts_top_checker.sv: timing relations on the sequencer's ports
// assumes one clock domain, srst synchronous and active high
`timescale 1ns/1ps
module ssts_top_checker #(
  parameter AW        = 8,
  parameter STEP_CYC  = 4,
  parameter FLASH_CYC = 3
) (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        test_start,
  input wire logic        menu_exit,
  input wire logic        group_avail_r,
  input wire logic [2:0]  ind_r,
  input wire logic        err_lamp_r,
  input wire logic        adc_req_r,
  input wire logic        adc_src_id_r,
  input wire logic [1:0]  adc_chan_r,
  input wire logic        adc_valid,
  input wire logic [15:0] adc_mvolt,
  input wire logic [15:0] disp_val_r,
  input wire logic [3:0]  relay_sw_r,
  input wire logic        relay_gauge_channel_one_r,
  input wire logic        relay_gauge_channel_two_r,
  input wire logic        relay_err_r,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        tx_valid_r,
  input wire logic [7:0]  tx_data_r
);
  localparam int BUSY_MAX = 300;
  logic [6:0]  vec;
  logic [6:0]  vec_q_r;
  logic        lamp_q_r;
  logic [31:0] rly_run_r;
  logic [31:0] lamp_run_r;
  logic        calm;
  assign vec = {relay_sw_r, relay_gauge_channel_one_r, relay_gauge_channel_two_r, relay_err_r};
  assign calm = !test_start && !menu_exit;
  always @(posedge ref_clk) begin
    vec_q_r <= vec;
    lamp_q_r <= err_lamp_r;
    rly_run_r <= (srst || vec == 7'h00 || vec != vec_q_r) ? 32'h0 : rly_run_r + 32'h1;
    lamp_run_r <= (srst || ind_r != 3'h3 || err_lamp_r != lamp_q_r) ? 32'h0 : lamp_run_r + 32'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_start_gated: assert property ((test_start && !group_avail_r && ind_r == 3'h0) |=> ind_r == 3'h0)
    else $error("test started while group hidden");
  a_busy_ends: assert property (ind_r == 3'h1 |-> ##[1:BUSY_MAX] ind_r != 3'h1)
    else $error("memory test never finished");
  a_lamp_cause: assert property (err_lamp_r |-> (ind_r == 3'h3 || $past(ind_r) == 3'h3))
    else $error("error lamp lit without failure");
  a_lamp_flashes: assert property (lamp_run_r <= FLASH_CYC)
    else $error("error lamp not flashing");
  a_adc_source: assert property (adc_req_r |-> adc_src_id_r == adc_chan_r[1])
    else $error("converter input source wrong");
  a_adc_shown: assert property ((ind_r == 3'h4 && adc_valid && calm) |=> disp_val_r == $past(adc_mvolt))
    else $error("sample not displayed");
  a_relay_single: assert property ($onehot0(vec))
    else $error("more than one relay on");
  a_relay_step: assert property (rly_run_r < STEP_CYC)
    else $error("relay step too long");
  a_echo_copy: assert property ((ind_r == 3'h7 && rx_valid && calm) |=> (tx_valid_r && tx_data_r == $past(rx_data)))
    else $error("character not echoed");
  a_result_held: assert property ((ind_r inside {3'h2, 3'h3} && calm) |=> (ind_r == $past(ind_r) && $stable(disp_val_r)))
    else $error("final indication lost");
  a_exit_clears: assert property (menu_exit |=> ind_r == 3'h0)
    else $error("leaving group kept indication");
endmodule
bind ssts_top ssts_top_checker #(.AW(AW), .STEP_CYC(STEP_CYC), .FLASH_CYC(FLASH_CYC)) u_chk (
  .ref_clk, .srst, .test_start, .menu_exit, .group_avail_r, .ind_r, .err_lamp_r, .adc_req_r, .adc_src_id_r,
  .adc_chan_r, .adc_valid, .adc_mvolt, .disp_val_r, .relay_sw_r, .relay_gauge_channel_one_r,
  .relay_gauge_channel_two_r, .relay_err_r, .rx_valid, .rx_data, .tx_valid_r, .tx_data_r);

// ---- test/ssts_top_test.sv ----
// ssts_top_test.sv: self-checking bench for the self-test sequencer
// assumes short step, flash and address parameters; memory answers its address in the same cycle
`timescale 1ns/1ps
module ssts_top_test;
  logic ref_clk, srst, svc_key, menu_exit, test_start, mem_rd_err, adc_valid, send_en;
  logic [3:0]  test_sel;
  logic [7:0]  mem_rd_data, send_byte, last_echo, echo_xor, n_echo, rx_data, tx_data_r, mem_addr_r;
  logic [15:0] adc_mvolt, disp_val_r;
  logic [2:0]  ind_r;
  logic [1:0]  mem_space_r, adc_chan_r;
  logic [3:0]  relay_sw_r;
  logic group_avail_r, mem_rd_r, adc_src_id_r, adc_req_r, disp_all_on_r, err_lamp_r, rx_valid, tx_valid_r;
  logic rly1, rly2, rly_err;
  int errors;
  int n_compared;
  ssts_top #(.AW(3), .STEP_CYC(4), .FLASH_CYC(3)) uut (.ref_clk, .srst, .svc_key, .menu_exit, .test_start,
    .test_sel, .group_avail_r, .mem_addr_r(mem_addr_r[2:0]), .mem_rd_r, .mem_space_r, .mem_rd_data, .mem_rd_err,
    .adc_chan_r, .adc_src_id_r, .adc_req_r, .adc_valid, .adc_mvolt, .ind_r, .disp_val_r, .disp_all_on_r,
    .err_lamp_r, .relay_sw_r, .relay_gauge_channel_one_r(rly1), .relay_gauge_channel_two_r(rly2),
    .relay_err_r(rly_err), .rx_valid, .rx_data, .tx_valid_r, .tx_data_r);
  ssts_host_model host (.ref_clk, .send_en, .send_byte, .rx_valid, .rx_data, .tx_valid_r, .tx_data_r,
    .last_echo, .echo_xor, .n_echo);
  // data only while the strobe stands, so a missing strobe or address step shows in the sum
  assign mem_rd_data = mem_rd_r ? 8'hA0 + {5'h00, mem_addr_r[2:0]} : 8'h00;
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("errors %0d, comparisons %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic key);
    @(posedge ref_clk);
    srst <= 1'b1;
    svc_key <= key;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    tick(3);
    chk(group_avail_r, key);
  endtask
  // memory error level is set together with the start so it holds for the whole scan
  task automatic start(input logic [3:0] sel, input logic bad);
    @(posedge ref_clk);
    test_sel <= sel;
    test_start <= 1'b1;
    mem_rd_err <= bad;
    @(posedge ref_clk);
    test_start <= 1'b0;
    tick(1);
  endtask
  task automatic t_mem(input logic [3:0] sel, input logic bad);
    logic lamp0;
    start(sel, bad);
    chk(ind_r, 3'h1);
    chk(mem_space_r, sel[1:0]);
    for (int i = 0; i < 100 && ind_r === 3'h1; i++) tick(1);
    chk(ind_r, bad ? 3'h3 : 3'h2);
    if (sel == 4'h1) chk(disp_val_r, 16'h051C);
    lamp0 = err_lamp_r;
    tick(4);
    chk(err_lamp_r !== lamp0, bad);
    chk(ind_r, bad ? 3'h3 : 3'h2);
  endtask
  task automatic t_adc(input logic [1:0] ch);
    start({2'b01, ch}, 1'b0);
    chk(ind_r, 3'h4);
    chk({adc_src_id_r, adc_req_r, adc_chan_r}, {ch[1], 1'b1, ch});
    @(posedge ref_clk);
    adc_valid <= 1'b1;
    adc_mvolt <= {8'hA0, 6'h00, ch};
    @(posedge ref_clk);
    adc_valid <= 1'b0;
    tick(2);
    chk(disp_val_r, {8'hA0, 6'h00, ch});
  endtask
  task automatic t_relay;
    logic [6:0] v, prev;
    logic [6:0] seen[$];
    logic [6:0] exp_seq[7] = '{7'h08, 7'h10, 7'h20, 7'h40, 7'h04, 7'h02, 7'h01};
    int on_cyc;
    on_cyc = 0;
    prev = 7'h00;
    start(4'h8, 1'b0);
    chk(ind_r, 3'h6);
    repeat (50) begin
      v = {relay_sw_r, rly1, rly2, rly_err};
      if (v != 7'h00) on_cyc++;
      if (v != 7'h00 && v != prev) seen.push_back(v);
      prev = v;
      tick(1);
    end
    chk(seen.size(), 7);
    for (int i = 0; i < 7; i++) chk(seen[i], exp_seq[i]);
    chk(on_cyc, 28);
    chk({v, ind_r}, {7'h00, 3'h6});
  endtask
  task automatic t_echo;
    start(4'h9, 1'b0);
    chk(ind_r, 3'h7);
    @(posedge ref_clk);
    send_en <= 1'b1;
    send_byte <= 8'h3C;
    @(posedge ref_clk);
    send_byte <= 8'hC3;
    @(posedge ref_clk);
    send_byte <= 8'h5A;
    @(posedge ref_clk);
    send_en <= 1'b0;
    tick(4);
    chk({n_echo, echo_xor}, {8'h03, 8'hA5});
    chk({last_echo, 5'h00, ind_r}, {8'h5A, 8'h07});
  endtask
  initial begin
    {ref_clk, srst, svc_key, menu_exit, test_start, mem_rd_err, adc_valid, send_en} = 8'h40;
    {test_sel, send_byte, adc_mvolt} = 28'h0;
    errors = 0;
    n_compared = 0;
    do_reset(1'b0);
    start(4'h0, 1'b0);
    chk(ind_r, 3'h0);
    do_reset(1'b1);
    start(4'hF, 1'b0);
    chk(ind_r, 3'h0);
    for (int s = 0; s < 3; s++) for (int b = 0; b < 2; b++) t_mem(s[3:0], b[0]);
    start(4'h3, 1'b0);
    chk({disp_all_on_r, ind_r}, 4'hD);
    for (int c = 0; c < 4; c++) t_adc(c[1:0]);
    t_relay();
    t_echo();
    @(posedge ref_clk);
    menu_exit <= 1'b1;
    @(posedge ref_clk);
    menu_exit <= 1'b0;
    tick(1);
    chk(ind_r, 3'h0);
    report_and_stop();
  end
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
